// file: fsr_host.sv
// Flow sensor host end: issues reset, identification and result reads.
module fsr_host #(
   parameter logic [6:0] DEV_ADDR = 7'h08,
   parameter logic [23:0] EXPECT_BASE = 24'h00_0100 // Arbitrary value.
) (
   input wire logic clock,
   input wire logic reset_n,
   fsr_link_if.host link,
   input wire logic op_valid,
   input fsr_pkg::fsr_op_t op_kind,
   output logic op_ready,
   output logic done,
   output logic nack_err,
   output logic crc_err,
   output logic [31:0] product,
   output logic [7:0] revision,
   output logic product_match,
   output logic [63:0] serial,
   output logic signed [31:0] flow_ul_min,
   output logic signed [31:0] temp_mdeg,
   output logic signed [31:0] dtemp_mdeg
);
   import fsr_pkg::*;

   typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} fsr_hstate_t;
   fsr_hstate_t st_reg, st_next;
   fsr_op_t op_reg, op_next;
   logic [4:0] step_reg, step_next;
   logic cv_reg, cv_next;
   fsr_kind_t kind_reg, kind_next;
   logic [7:0] cb_reg, cb_next;
   logic more_reg, more_next;
   logic [1:0] ph_reg, ph_next;
   logic [15:0] word_reg, word_next;
   logic [95:0] buf_reg, buf_next;
   logic done_reg, done_next;
   logic rdy_reg, rdy_next;
   logic nack_reg, nack_next;
   logic crc_reg, crc_next;
   logic [31:0] prod_reg, prod_next;
   logic match_reg, match_next;
   logic [63:0] ser_reg, ser_next;
   logic signed [31:0] flow_reg, flow_next, temp_reg, temp_next, dt_reg, dt_next;
   fsr_kind_t s_kind;
   logic [7:0] s_byte;
   logic s_more;
   logic [4:0] s_stop;

   // Script of link events for each operation and step.
   always_comb
   begin
      s_kind = K_STOP;
      s_byte = 8'h00;
      s_more = 1'b0;
      s_stop = RST_STOP;
      case (op_reg)
         OP_RESET:
         begin
            if (step_reg == 5'h00)
            begin
               s_kind = K_HDR;
               s_byte = GC_HDR;
            end
            else if (step_reg == 5'h01)
            begin
               s_kind = K_WR;
               s_byte = CMD_SOFT_RESET;
            end
         end
         OP_READ_ID:
         begin
            s_stop = ID_STOP;
            case (step_reg)
               5'h00, 5'h04: s_kind = K_HDR;
               5'h01: s_kind = K_WR;
               5'h02: s_kind = K_WR;
               5'h05: s_kind = K_WR;
               5'h06: s_kind = K_WR;
               5'h08: s_kind = K_HDR;
               default: s_kind = (step_reg > 5'h08 && step_reg <= ID_RD_LAST) ? K_RD : K_STOP;
            endcase
            case (step_reg)
               5'h00, 5'h04: s_byte = {DEV_ADDR, 1'b0};
               5'h01: s_byte = CMD_ID_FIRST[15:8];
               5'h02: s_byte = CMD_ID_FIRST[7:0];
               5'h05: s_byte = CMD_ID_SECOND[15:8];
               5'h06: s_byte = CMD_ID_SECOND[7:0];
               5'h08: s_byte = {DEV_ADDR, 1'b1};
               default: s_byte = 8'h00;
            endcase
            s_more = step_reg != ID_RD_LAST;
         end
         default:
         begin
            s_stop = RES_STOP;
            if (step_reg == 5'h00)
            begin
               s_kind = K_HDR;
               s_byte = {DEV_ADDR, 1'b1};
            end
            else if (step_reg <= RES_RD_LAST)
            begin
               s_kind = K_RD;
            end
            s_more = step_reg != RES_RD_LAST;
         end
      endcase
   end

   // Sequencer: issue one event, wait for its answer, gather words.
   always_comb
   begin
      st_next = st_reg;
      op_next = op_reg;
      step_next = step_reg;
      cv_next = 1'b0;
      kind_next = kind_reg;
      cb_next = cb_reg;
      more_next = more_reg;
      ph_next = ph_reg;
      word_next = word_reg;
      buf_next = buf_reg;
      done_next = 1'b0;
      nack_next = nack_reg;
      crc_next = crc_reg;
      prod_next = prod_reg;
      match_next = match_reg;
      ser_next = ser_reg;
      flow_next = flow_reg;
      temp_next = temp_reg;
      dt_next = dt_reg;
      case (st_reg)
         H_IDLE:
         begin
            if (op_valid)
            begin
               op_next = op_kind;
               step_next = 5'h00;
               ph_next = 2'h0;
               nack_next = 1'b0;
               crc_next = 1'b0;
               st_next = H_ISSUE;
            end
         end
         H_ISSUE:
         begin
            cv_next = 1'b1;
            kind_next = s_kind;
            cb_next = s_byte;
            more_next = s_more;
            st_next = H_WAIT;
         end
         H_WAIT:
         begin
            if (link.rsp_valid)
            begin
               step_next = step_reg + 5'h01;
               st_next = H_ISSUE;
               if (kind_reg == K_HDR && !link.rsp_ack)
               begin
                  nack_next = 1'b1;
                  step_next = s_stop;
               end
               if (kind_reg == K_RD)
               begin
                  ph_next = ph_reg == CRC_PHASE ? 2'h0 : ph_reg + 2'h1;
                  if (ph_reg != CRC_PHASE)
                  begin
                     word_next = {word_reg[7:0], link.rsp_byte};
                  end
                  else
                  begin
                     buf_next = {buf_reg[79:0], word_reg};
                     if (fsr_crc8(word_reg) != link.rsp_byte)
                     begin
                        crc_next = 1'b1;
                     end
                  end
               end
               if (step_reg == s_stop)
               begin
                  st_next = H_IDLE;
                  done_next = 1'b1;
                  if (op_reg == OP_READ_ID && !nack_reg)
                  begin
                     prod_next = buf_reg[95:64];
                     match_next = buf_reg[95:72] == EXPECT_BASE;
                     ser_next = buf_reg[63:0];
                  end
                  if (op_reg == OP_READ_RES && !nack_reg)
                  begin
                     flow_next = 32'(int'($signed(buf_reg[47:32])) * FLOW_MUL);
                     temp_next = 32'(int'($signed(buf_reg[31:16])) * TEMP_MUL);
                     dt_next = 32'(int'($signed(buf_reg[15:0])) * DT_MUL);
                  end
               end
            end
         end
         default: st_next = H_IDLE;
      endcase
      // Ready is registered so that the output comes straight from a flip-flop.
      rdy_next = st_next == H_IDLE ? 1'b1 : 1'b0;
   end

   // Registers the sequencer and the results.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_reg <= H_IDLE;
         op_reg <= OP_RESET;
         step_reg <= 5'h00;
         cv_reg <= 1'b0;
         kind_reg <= K_STOP;
         cb_reg <= 8'h00;
         more_reg <= 1'b0;
         ph_reg <= 2'h0;
         word_reg <= 16'h0000;
         buf_reg <= 96'h0;
         done_reg <= 1'b0;
         rdy_reg <= 1'b1;
         nack_reg <= 1'b0;
         crc_reg <= 1'b0;
         prod_reg <= 32'h0000_0000;
         match_reg <= 1'b0;
         ser_reg <= 64'h0000_0000_0000_0000;
         flow_reg <= 32'sh0000_0000;
         temp_reg <= 32'sh0000_0000;
         dt_reg <= 32'sh0000_0000;
      end
      else
      begin
         st_reg <= st_next;
         op_reg <= op_next;
         step_reg <= step_next;
         cv_reg <= cv_next;
         kind_reg <= kind_next;
         cb_reg <= cb_next;
         more_reg <= more_next;
         ph_reg <= ph_next;
         word_reg <= word_next;
         buf_reg <= buf_next;
         done_reg <= done_next;
         rdy_reg <= rdy_next;
         nack_reg <= nack_next;
         crc_reg <= crc_next;
         prod_reg <= prod_next;
         match_reg <= match_next;
         ser_reg <= ser_next;
         flow_reg <= flow_next;
         temp_reg <= temp_next;
         dt_reg <= dt_next;
      end
   end

   // Outputs straight from flip-flops.
   assign link.cmd_valid = cv_reg;
   assign link.cmd_kind = kind_reg;
   assign link.cmd_byte = cb_reg;
   assign link.cmd_more = more_reg;
   assign op_ready = rdy_reg;
   assign done = done_reg;
   assign nack_err = nack_reg;
   assign crc_err = crc_reg;
   assign product = prod_reg;
   assign revision = prod_reg[7:0];
   assign product_match = match_reg;
   assign serial = ser_reg;
   assign flow_ul_min = flow_reg;
   assign temp_mdeg = temp_reg;
   assign dtemp_mdeg = dt_reg;
endmodule : fsr_host

// file: fsr_pkg.sv
// Shared constants, types and checksum function of the flow sensor link.
package fsr_pkg;
   // Clock rate and soft reset time.
   localparam int CLK_KHZ = 200000;
   localparam int RESET_MAX_MS = 25;
   localparam int RESET_CYC = RESET_MAX_MS * CLK_KHZ;
   // Header and command codes.
   localparam logic [7:0] GC_HDR = 8'h00;
   localparam logic [7:0] CMD_SOFT_RESET = 8'h06;
   localparam logic [15:0] CMD_ID_FIRST = 16'h367c;
   localparam logic [15:0] CMD_ID_SECOND = 16'he102;
   // Checksum definition.
   localparam logic [7:0] CRC_POLY = 8'h31;
   localparam logic [7:0] CRC_INIT = 8'hff;
   localparam logic [7:0] CRC_XOR = 8'h00;
   // Readout shapes.
   localparam int ID_WORDS = 6;
   localparam int RES_WORDS = 3;
   localparam logic [1:0] CRC_PHASE = 2'h2;
   localparam int FLOW_MAX = 32500;
   // Scale factors and the milli-unit multipliers derived from them.
   localparam int FLOW_SCALE = 500;
   localparam int TEMP_SCALE = 200;
   localparam int DT_SCALE = 1000;
   localparam int OUT_MILLI = 1000;
   localparam int FLOW_MUL = OUT_MILLI / FLOW_SCALE;
   localparam int TEMP_MUL = OUT_MILLI / TEMP_SCALE;
   localparam int DT_MUL = OUT_MILLI / DT_SCALE;
   // Host script step numbers.
   localparam logic [4:0] RST_STOP = 5'h02;
   localparam logic [4:0] ID_RD_LAST = 5'h1a;
   localparam logic [4:0] ID_STOP = 5'h1b;
   localparam logic [4:0] RES_RD_LAST = 5'h09;
   localparam logic [4:0] RES_STOP = 5'h0a;
   // Link events, device modes and host operations.
   typedef enum logic [1:0] {K_HDR, K_WR, K_RD, K_STOP} fsr_kind_t;
   typedef enum logic [2:0] {M_IDLE, M_GC, M_WRITE, M_ID, M_RES} fsr_mode_t;
   typedef enum logic [1:0] {OP_RESET, OP_READ_ID, OP_READ_RES} fsr_op_t;

   // Checksum over one 16-bit word, MSB first, no reflection.
   function automatic logic [7:0] fsr_crc8(input logic [15:0] word);
      logic [7:0] crc;
      crc = CRC_INIT;
      for (int i = 15; i >= 0; i--)
      begin
         if (crc[7] ^ word[i])
         begin
            crc = {crc[6:0], 1'b0} ^ CRC_POLY;
         end
         else
         begin
            crc = {crc[6:0], 1'b0};
         end
      end
      return crc ^ CRC_XOR;
   endfunction : fsr_crc8
endpackage : fsr_pkg

// file: fsr_link_if.sv
// Byte-level bus link between the sensor device end and the host end.
interface fsr_link_if (
   input wire logic clock,
   input wire logic reset_n
);
   // Host events: header, written byte, read byte request or stop.
   logic cmd_valid;
   fsr_pkg::fsr_kind_t cmd_kind;
   logic [7:0] cmd_byte;
   logic cmd_more;
   // Device answer to each event, one cycle later.
   logic rsp_valid;
   logic rsp_ack;
   logic [7:0] rsp_byte;

   modport dev (input cmd_valid, input cmd_kind, input cmd_byte, input cmd_more,
                output rsp_valid, output rsp_ack, output rsp_byte);
   modport host (output cmd_valid, output cmd_kind, output cmd_byte, output cmd_more,
                 input rsp_valid, input rsp_ack, input rsp_byte);
endinterface : fsr_link_if

// file: fsr_dev.sv
// Flow sensor device end: soft reset, identification readout and word checksums.
module fsr_dev #(
   parameter logic [6:0] DEV_ADDR = 7'h08,
   parameter int RESET_CYCLES = fsr_pkg::RESET_CYC,
   parameter logic [23:0] PRODUCT_BASE = 24'h00_0100, // Arbitrary value.
   parameter logic [7:0] REVISION = 8'h01, // Arbitrary value.
   parameter logic [63:0] SERIAL = 64'h0000_0000_0000_0001 // Arbitrary value.
) (
   input wire logic clock,
   input wire logic reset_n,
   fsr_link_if.dev link,
   input wire logic res_valid,
   input wire logic signed [17:0] res_flow_raw,
   input wire logic [31:0] res_aux,
   output logic busy,
   output logic id_ready
);
   import fsr_pkg::*;

   fsr_mode_t mode_reg, mode_next;
   logic busy_reg, busy_next;
   logic [31:0] cnt_reg, cnt_next;
   logic [1:0] stage_reg, stage_next;
   logic [7:0] hi_reg, hi_next;
   logic wcnt_reg, wcnt_next;
   logic [2:0] word_reg, word_next;
   logic [1:0] phase_reg, phase_next;
   logic rv_reg, rv_next;
   logic ack_reg, ack_next;
   logic [7:0] byte_reg, byte_next;
   logic [95:0] id_all;
   logic [15:0] flow_word;
   logic [47:0] res_all;
   logic [15:0] cur_word;
   logic [7:0] cur_byte;

   // Builds the word under the read pointer and the byte of the current phase.
   always_comb
   begin
      id_all = {PRODUCT_BASE, REVISION, SERIAL};
      if (int'(res_flow_raw) > FLOW_MAX)
      begin
         flow_word = 16'(FLOW_MAX);
      end
      else if (int'(res_flow_raw) < -FLOW_MAX)
      begin
         flow_word = 16'(-FLOW_MAX);
      end
      else
      begin
         flow_word = res_flow_raw[15:0];
      end
      res_all = {flow_word, res_aux};
      cur_word = 16'hffff;
      if (mode_reg == M_ID && int'(word_reg) < ID_WORDS)
      begin
         cur_word = id_all[95 - 16 * int'(word_reg) -: 16];
      end
      else if (mode_reg == M_RES && int'(word_reg) < RES_WORDS)
      begin
         cur_word = res_all[47 - 16 * int'(word_reg) -: 16];
      end
      case (phase_reg)
         2'h0: cur_byte = cur_word[15:8];
         2'h1: cur_byte = cur_word[7:0];
         default: cur_byte = fsr_crc8(cur_word);
      endcase
   end

   // Next state of the protocol engine, the reset timer and the answer.
   always_comb
   begin
      mode_next = mode_reg;
      busy_next = busy_reg;
      cnt_next = cnt_reg;
      stage_next = stage_reg;
      hi_next = hi_reg;
      wcnt_next = wcnt_reg;
      word_next = word_reg;
      phase_next = phase_reg;
      rv_next = 1'b0;
      ack_next = 1'b0;
      byte_next = 8'hff;
      // Counts out the soft reset time.
      if (busy_reg)
      begin
         cnt_next = cnt_reg - 32'h0000_0001;
         if (cnt_reg <= 32'h0000_0001)
         begin
            busy_next = 1'b0;
         end
      end
      if (link.cmd_valid)
      begin
         rv_next = 1'b1;
         case (link.cmd_kind)
            K_HDR:
            begin
               mode_next = M_IDLE;
               wcnt_next = 1'b0;
               word_next = 3'h0;
               phase_next = 2'h0;
               if (busy_reg)
               begin
                  ack_next = 1'b0;
               end
               else if (link.cmd_byte == GC_HDR)
               begin
                  ack_next = 1'b1;
                  mode_next = M_GC;
               end
               else if (link.cmd_byte[7:1] == DEV_ADDR && !link.cmd_byte[0])
               begin
                  ack_next = 1'b1;
                  mode_next = M_WRITE;
               end
               else if (link.cmd_byte[7:1] == DEV_ADDR && stage_reg == 2'h2)
               begin
                  ack_next = 1'b1;
                  mode_next = M_ID;
               end
               else if (link.cmd_byte[7:1] == DEV_ADDR && res_valid)
               begin
                  ack_next = 1'b1;
                  mode_next = M_RES;
               end
               else
               begin
                  ack_next = 1'b0;
               end
            end
            K_WR:
            begin
               if (mode_reg == M_GC)
               begin
                  ack_next = 1'b1;
                  mode_next = M_IDLE;
                  if (link.cmd_byte == CMD_SOFT_RESET)
                  begin
                     busy_next = 1'b1;
                     cnt_next = 32'(RESET_CYCLES);
                     stage_next = 2'h0;
                  end
               end
               else if (mode_reg == M_WRITE)
               begin
                  ack_next = 1'b1;
                  wcnt_next = ~wcnt_reg;
                  hi_next = link.cmd_byte;
                  // A full 16-bit code steps the identification sequence.
                  if (wcnt_reg && {hi_reg, link.cmd_byte} == CMD_ID_FIRST)
                  begin
                     stage_next = 2'h1;
                  end
                  else if (wcnt_reg && {hi_reg, link.cmd_byte} == CMD_ID_SECOND && stage_reg != 2'h0)
                  begin
                     stage_next = 2'h2;
                  end
                  else if (wcnt_reg)
                  begin
                     stage_next = 2'h0;
                  end
               end
            end
            K_RD:
            begin
               if (mode_reg == M_ID || mode_reg == M_RES)
               begin
                  ack_next = 1'b1;
                  byte_next = cur_byte;
                  // Three bytes per word: high, low, checksum.
                  if (phase_reg == CRC_PHASE)
                  begin
                     phase_next = 2'h0;
                     word_next = word_reg + 3'h1;
                  end
                  else
                  begin
                     phase_next = phase_reg + 2'h1;
                  end
                  if (!link.cmd_more)
                  begin
                     mode_next = M_IDLE;
                  end
               end
            end
            default:
            begin
               ack_next = 1'b1;
               mode_next = M_IDLE;
            end
         endcase
      end
   end

   // Registers the protocol engine state.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mode_reg <= M_IDLE;
         busy_reg <= 1'b0;
         cnt_reg <= 32'h0000_0000;
         stage_reg <= 2'h0;
         hi_reg <= 8'h00;
         wcnt_reg <= 1'b0;
         word_reg <= 3'h0;
         phase_reg <= 2'h0;
         rv_reg <= 1'b0;
         ack_reg <= 1'b0;
         byte_reg <= 8'hff;
      end
      else
      begin
         mode_reg <= mode_next;
         busy_reg <= busy_next;
         cnt_reg <= cnt_next;
         stage_reg <= stage_next;
         hi_reg <= hi_next;
         wcnt_reg <= wcnt_next;
         word_reg <= word_next;
         phase_reg <= phase_next;
         rv_reg <= rv_next;
         ack_reg <= ack_next;
         byte_reg <= byte_next;
      end
   end

   // Outputs straight from flip-flops.
   assign link.rsp_valid = rv_reg;
   assign link.rsp_ack = ack_reg;
   assign link.rsp_byte = byte_reg;
   assign busy = busy_reg;
   assign id_ready = stage_reg[1]; // Stage two is the only code with its upper bit set.
endmodule : fsr_dev

// file: fsr_link_chk.sv
// Concurrent assertions on the link between the sensor device end and the host end.
module fsr_chk #(
   parameter int RESET_CYCLES = 20
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input fsr_pkg::fsr_kind_t cmd_kind,
   input wire logic [7:0] cmd_byte,
   input wire logic rsp_valid,
   input wire logic rsp_ack,
   input wire logic [7:0] rsp_byte
);
   import fsr_pkg::*;
   logic rd_reg;
   logic gc_reg;
   logic [1:0] ph_reg;
   logic [15:0] word_reg;
   int rst_reg;

   // Checksum of one word, worked out here apart from the design.
   function automatic logic [7:0] chk_crc(input logic [15:0] w);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 15; i >= 0; i--)
      begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
      end
      return c;
   endfunction : chk_crc

   // Follows read byte phases, the last word read and the soft reset window.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rd_reg <= 1'b0;
         gc_reg <= 1'b0;
         ph_reg <= 2'h0;
         word_reg <= 16'h0000;
         rst_reg <= 0;
      end
      else
      begin
         rd_reg <= cmd_valid && cmd_kind == K_RD;
         if (cmd_valid && cmd_kind == K_HDR)
         begin
            gc_reg <= cmd_byte == GC_HDR;
            ph_reg <= 2'h0;
         end
         else if (rsp_valid && rd_reg && rsp_ack)
         begin
            ph_reg <= (ph_reg == CRC_PHASE) ? 2'h0 : ph_reg + 2'h1;
            word_reg <= {word_reg[7:0], rsp_byte};
         end
         if (gc_reg && cmd_valid && cmd_kind == K_WR && cmd_byte == CMD_SOFT_RESET && rst_reg == 0)
         begin
            rst_reg <= RESET_CYCLES + 2;
         end
         else if (rst_reg > 0)
         begin
            rst_reg <= rst_reg - 1;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   // Steps of the general call reset and of the first identification command.
   sequence s_gc_hdr;
      cmd_valid && cmd_kind == K_HDR && cmd_byte == GC_HDR;
   endsequence
   sequence s_gc_cmd;
      cmd_valid && cmd_kind == K_WR && cmd_byte == CMD_SOFT_RESET;
   endsequence
   sequence s_id_first;
      cmd_valid && cmd_kind == K_WR && cmd_byte == CMD_ID_FIRST[15:8] ##3
      cmd_valid && cmd_kind == K_WR && cmd_byte == CMD_ID_FIRST[7:0];
   endsequence

   // Every request has one answer, exactly one cycle later.
   a_rsp_follows: assert property (cmd_valid |=> rsp_valid)
      else $error("Request without answer.");
   a_rsp_caused: assert property (!cmd_valid |=> !rsp_valid)
      else $error("Answer without request.");
   // General call handling and the window in which the device stays deaf.
   a_gc_hdr_ack: assert property (s_gc_hdr ##0 rst_reg == 0 |=> rsp_ack)
      else $error("General call header refused.");
   a_gc_then_cmd: assert property (s_gc_hdr |-> ##3 s_gc_cmd)
      else $error("Reset byte does not follow the general call.");
   a_busy_nack: assert property ((cmd_valid && (cmd_kind == K_HDR || cmd_kind == K_WR) && rst_reg > 4) |=> !rsp_ack)
      else $error("Request accepted during soft reset.");
   // Two identification commands, each in its own write transfer.
   a_id_pair: assert property (s_id_first |-> ##3 cmd_valid && cmd_kind == K_STOP ##3 cmd_valid && cmd_kind == K_HDR
      ##3 cmd_valid && cmd_kind == K_WR && cmd_byte == CMD_ID_SECOND[15:8])
      else $error("Second identification command missing.");
   // Checksum byte covers the two data bytes just before it.
   a_crc_word: assert property (rsp_valid && rd_reg && rsp_ack && ph_reg == CRC_PHASE |->
      rsp_byte == chk_crc(word_reg))
      else $error("Wrong checksum byte.");
   a_idle_ff: assert property (rsp_valid && !(rd_reg && rsp_ack) |-> rsp_byte == 8'hff)
      else $error("Data byte outside a read.");
endmodule : fsr_chk

// file: fsr_tb.sv
// Self-checking bench joining the device end and the host end of the sensor link.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import fsr_pkg::*;
   localparam int RST_CYC = 20;
   localparam logic [23:0] BASE = 24'h5a_c3e1; // Arbitrary value.
   localparam logic [7:0] REV = 8'h7e; // Arbitrary value.
   localparam logic [63:0] SER = 64'h0123_4567_89ab_cdef; // Arbitrary value.
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic op_valid = 1'b0;
   fsr_op_t op_kind = OP_RESET;
   logic res_valid = 1'b0;
   logic signed [17:0] res_flow_raw = '0;
   logic [31:0] res_aux = '0;
   logic op_ready, done, nack_err, crc_err, product_match, busy, id_ready;
   logic [31:0] product;
   logic [7:0] revision;
   logic [63:0] serial;
   logic signed [31:0] flow_ul_min, temp_mdeg, dtemp_mdeg;
   int n_errors = 0;
   int check_count = 0;

   // Clock at 200 MHz.
   always #2.5 clock = ~clock;

   fsr_link_if link (.clock(clock), .reset_n(reset_n));
   fsr_dev #(.RESET_CYCLES(RST_CYC), .PRODUCT_BASE(BASE), .REVISION(REV), .SERIAL(SER)) u_fsr_dev (
      .clock(clock), .reset_n(reset_n), .link(link), .res_valid(res_valid), .res_flow_raw(res_flow_raw),
      .res_aux(res_aux), .busy(busy), .id_ready(id_ready));
   fsr_host #(.EXPECT_BASE(BASE)) u_fsr_host (.clock(clock), .reset_n(reset_n), .link(link),
      .op_valid(op_valid), .op_kind(op_kind), .op_ready(op_ready), .done(done), .nack_err(nack_err),
      .crc_err(crc_err), .product(product), .revision(revision), .product_match(product_match),
      .serial(serial), .flow_ul_min(flow_ul_min), .temp_mdeg(temp_mdeg), .dtemp_mdeg(dtemp_mdeg));
   fsr_chk #(.RESET_CYCLES(RST_CYC)) u_fsr_chk (.clock(clock), .reset_n(reset_n), .cmd_valid(link.cmd_valid),
      .cmd_kind(link.cmd_kind), .cmd_byte(link.cmd_byte), .rsp_valid(link.rsp_valid), .rsp_ack(link.rsp_ack),
      .rsp_byte(link.rsp_byte));

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test

   // Compares one flag.
   task automatic chk_bit(input logic got, input logic exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask : chk_bit

   // Compares one value.
   task automatic chk_val(input logic [63:0] got, input logic [63:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t %s got %h", $time, what, got);
      end
   endtask : chk_val

   // Starts one host operation and waits a bounded time for its end.
   task automatic run_op(input fsr_op_t kind);
      op_kind = kind;
      op_valid = 1'b1;
      @(negedge clock);
      op_valid = 1'b0;
      for (int i = 0; i < 200; i++)
      begin
         @(negedge clock);
         if (done === 1'b1)
            return;
      end
      n_errors++;
      $display("MISMATCH %0t operation hangs", $time);
      stop_test();
   endtask : run_op

   // Identification readout with a revision that differs from any fixed value.
   task automatic t_ident();
      run_op(OP_READ_ID);
      chk_bit(nack_err, 1'b0, "id refused");
      chk_bit(crc_err, 1'b0, "id checksum");
      chk_bit(op_ready, 1'b1, "not ready after op");
      chk_bit(id_ready, 1'b1, "id commands");
      chk_val(product, {BASE, REV}, "product");
      chk_val(revision, REV, "revision");
      chk_bit(product_match, 1'b1, "product match");
      chk_val(serial, SER, "serial");
      $display("Test ident ended");
   endtask : t_ident

   // Soft reset, deaf window, then a read with no result available.
   task automatic t_reset();
      run_op(OP_RESET);
      chk_bit(busy, 1'b1, "reset not started");
      chk_bit(id_ready, 1'b0, "id state kept");
      run_op(OP_READ_ID);
      chk_bit(nack_err, 1'b1, "address taken in reset");
      repeat (RST_CYC) @(negedge clock);
      chk_bit(busy, 1'b0, "reset stuck");
      run_op(OP_READ_RES);
      chk_bit(nack_err, 1'b1, "read without result");
      $display("Test reset ended");
   endtask : t_reset

   // Result words across the flow limits and signed conversions.
   task automatic t_result();
      int raw [5] = '{1234, 40000, -40000, 32500, -32501};
      int fl;
      res_valid = 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         res_flow_raw = 18'(raw[i]);
         res_aux = {16'(-400 + 7 * i), 16'(10000 - i)};
         fl = (raw[i] > FLOW_MAX) ? FLOW_MAX : (raw[i] < -FLOW_MAX) ? -FLOW_MAX : raw[i];
         run_op(OP_READ_RES);
         chk_bit(nack_err, 1'b0, "result refused");
         chk_bit(crc_err, 1'b0, "result checksum");
         chk_val(flow_ul_min, fl * OUT_MILLI / FLOW_SCALE, "flow");
         chk_val(temp_mdeg, (-400 + 7 * i) * OUT_MILLI / TEMP_SCALE, "temp");
         chk_val(dtemp_mdeg, (10000 - i) * OUT_MILLI / DT_SCALE, "dtemp");
      end
      $display("Test result ended");
   endtask : t_result

   // Main sequence.
   initial
   begin
      repeat (12) @(negedge clock);
      reset_n = 1'b1;
      @(negedge clock);
      t_ident();
      t_reset();
      t_result();
      stop_test();
   end
endmodule : tb
